// *** rtl/servo_motion_limiter_defs.svh ***
// servo_motion_limiter_defs.svh: offsets, widths, codes and reset values as macros
// assumes inclusion by bare name from the package and the design files
`ifndef SERVO_MOTION_LIMITER_DEFS_SVH
`define SERVO_MOTION_LIMITER_DEFS_SVH

// data widths
`define SML_TQ_W 16
`define SML_SPD_W 32
`define SML_POS_W 32
`define SML_ACC_W 32

// torque limit source selector codes
`define SML_SEL_PEAK 2'h0
`define SML_SEL_TORQUE 2'h1
`define SML_SEL_ANALOG 2'h2

// operating mode codes
`define SML_MODE_TORQUE 2'h0
`define SML_MODE_SPEED 2'h1
`define SML_MODE_POSITION 2'h2

// limit-reached detail bit positions
`define SML_LIM_TORQUE 0
`define SML_LIM_SPEED 1
`define SML_LIM_HW_POS 2
`define SML_LIM_HW_NEG 3
`define SML_LIM_SW_POS 4
`define SML_LIM_SW_NEG 5

// motion-parameter-limited detail bit positions
`define SML_PRM_SPEED 0
`define SML_PRM_ACCEL 1
`define SML_PRM_DECEL 2

// parameter soft error detail bit position
`define SML_ERR_SOFT_LIMITS 0

// torque scale: tenths of a percent of stall current, 100 percent reads 1000
`define SML_TQ_SCALE 16'h000A
`define SML_TQ_FULL 16'h03E8

// reset values
`define SML_RST_TQ 16'h0000
`define SML_RST_DETAIL 6'h00
`define SML_RST_PRM 3'h0

`endif

// *** rtl/servo_motion_limiter_pkg.sv ***
// servo_motion_limiter_pkg: types shared by the motion limiter files
// assumes servo_motion_limiter_defs.svh is on the include path
`include "servo_motion_limiter_defs.svh"

package servo_motion_limiter_pkg;

  typedef enum logic [1:0] {
    SEL_PEAK = 2'h0,
    SEL_TORQUE = 2'h1,
    SEL_ANALOG = 2'h2,
    SEL_RSVD = 2'h3
  } torque_src_type;

  typedef enum logic [1:0] {
    DRV_OP_ENABLED = 2'h0,
    DRV_QUICK_STOP = 2'h1
  } drive_state_type;

  typedef struct packed {
    logic [`SML_TQ_W-1:0] user_current_ceiling;
    logic [`SML_TQ_W-1:0] rated_current_ceiling;
    logic [`SML_TQ_W-1:0] torque_ceiling;
    logic [`SML_TQ_W-1:0] torque_limit_pos_value;
    logic [`SML_TQ_W-1:0] torque_limit_neg_value;
    logic [`SML_TQ_W-1:0] analog_torque_limit;
    torque_src_type torque_limit_source_sel;
  } torque_cfg_type;

  typedef struct packed {
    logic [`SML_SPD_W-1:0] speed_ceiling;
    logic [`SML_SPD_W-1:0] profile_speed_ceiling;
    logic [`SML_ACC_W-1:0] profile_accel_ceiling;
    logic [`SML_ACC_W-1:0] profile_decel_ceiling;
  } motion_cfg_type;

  typedef struct packed {
    logic soft_travel_limit_on;
    logic [`SML_POS_W-1:0] soft_travel_max;
    logic [`SML_POS_W-1:0] soft_travel_min;
  } travel_cfg_type;

  typedef struct packed {
    logic [`SML_SPD_W-1:0] speed;
    logic [`SML_ACC_W-1:0] accel;
    logic [`SML_ACC_W-1:0] decel;
  } profile_type;

endpackage

// *** rtl/torque_limit_select.sv ***
// torque_limit_select: picks the torque limit source and reports the applied limits
// assumes all inputs come from logic on i_clk_sys; outputs registered but the clamp flag
`timescale 1ns/1ps
`include "servo_motion_limiter_defs.svh"

module torque_limit_select (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // configuration
  input wire servo_motion_limiter_pkg::torque_cfg_type i_cfg,
  // torque demand, signed, tenths of a percent of stall current
  input wire logic signed [`SML_TQ_W-1:0] i_torque_demand,
  // applied limits and clamped demand
  output logic [`SML_TQ_W-1:0] o_limit_pos,
  output logic [`SML_TQ_W-1:0] o_limit_neg,
  output logic signed [`SML_TQ_W-1:0] o_torque_out,
  output logic o_clamping
);

  function automatic logic [`SML_TQ_W-1:0] umin(input logic [`SML_TQ_W-1:0] a,
                                               input logic [`SML_TQ_W-1:0] b);
    umin = (a < b) ? a : b;
  endfunction

  logic [`SML_TQ_W-1:0] cur_cap;
  logic [`SML_TQ_W-1:0] lim_pos_nxt;
  logic [`SML_TQ_W-1:0] lim_neg_nxt;
  logic signed [`SML_TQ_W:0] dem_ext;
  logic signed [`SML_TQ_W:0] pos_ext;
  logic signed [`SML_TQ_W:0] neg_ext;

  // the user ceiling always caps the current, whatever the source
  assign cur_cap = umin(i_cfg.user_current_ceiling, i_cfg.rated_current_ceiling);

  always_comb begin
    case (i_cfg.torque_limit_source_sel)
      servo_motion_limiter_pkg::SEL_PEAK: begin
        lim_pos_nxt = cur_cap;
        lim_neg_nxt = cur_cap;
      end
      servo_motion_limiter_pkg::SEL_TORQUE: begin
        lim_pos_nxt = umin(cur_cap, umin(i_cfg.torque_ceiling, i_cfg.torque_limit_pos_value));
        lim_neg_nxt = umin(cur_cap, umin(i_cfg.torque_ceiling, i_cfg.torque_limit_neg_value));
      end
      servo_motion_limiter_pkg::SEL_ANALOG: begin
        lim_pos_nxt = umin(cur_cap, i_cfg.analog_torque_limit);
        lim_neg_nxt = umin(cur_cap, i_cfg.analog_torque_limit);
      end
      default: begin
        // unused code falls back to the peak source
        lim_pos_nxt = cur_cap;
        lim_neg_nxt = cur_cap;
      end
    endcase
  end

  assign dem_ext = {i_torque_demand[`SML_TQ_W-1], i_torque_demand};
  assign pos_ext = {1'b0, lim_pos_nxt};
  assign neg_ext = -{1'b0, lim_neg_nxt};
  // unregistered so the warning lines up with the clamped demand
  assign o_clamping = (dem_ext > pos_ext) || (dem_ext < neg_ext);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_limit_pos <= `SML_RST_TQ;
      o_limit_neg <= `SML_RST_TQ;
    end else begin
      o_limit_pos <= lim_pos_nxt;
      o_limit_neg <= lim_neg_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_torque_out <= `SML_RST_TQ;
    end else if (dem_ext > pos_ext) begin
      o_torque_out <= lim_pos_nxt;
    end else if (dem_ext < neg_ext) begin
      o_torque_out <= neg_ext[`SML_TQ_W-1:0];
    end else begin
      o_torque_out <= i_torque_demand;
    end
  end

endmodule // torque_limit_select

// *** rtl/servo_motion_limiter.sv ***
// servo_motion_limiter: motion limit supervisor of a servo drive
// assumes parameters arrive from the fieldbus side on i_clk_sys; end switches are pins
//
// Functional notes
// - user current ceiling caps motor current
// - torque limit from one of three sources
// - applied positive and negative limits are readable
// - torque clamping raises limit-reached torque detail
// - torque values in tenths of stall percent
// - speed magnitude clamped symmetrically to ceiling
// - speed clamp only in speed, position modes
// - speed clamp raises limit-reached speed detail
// - reverse polarity swaps end switch roles
// - request into active end switch: quick stop
// - quick stop active until motor stationary
// - hardware limit warning held while limiting
// - opposite-side switch: no stop, no indication
// - request beyond soft travel limit: quick stop
// - soft limit warning held while limiting
// - max below min raises parameter soft error
// - profile speed clamped to lower ceiling
// - profile accel and decel clamped to ceilings
// - profile clamping raises motion-parameter-limited warning
`timescale 1ns/1ps
`include "servo_motion_limiter_defs.svh"

module servo_motion_limiter (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // configuration from the master
  input wire servo_motion_limiter_pkg::torque_cfg_type i_torque_cfg,
  input wire servo_motion_limiter_pkg::motion_cfg_type i_motion_cfg,
  input wire servo_motion_limiter_pkg::travel_cfg_type i_travel_cfg,
  input wire logic i_polarity_reverse,
  input wire logic [1:0] i_op_mode,
  input wire logic i_op_enabled,
  // live demands and feedback
  input wire logic signed [`SML_SPD_W-1:0] i_speed_request,
  input wire logic signed [`SML_TQ_W-1:0] i_torque_request,
  input wire logic signed [`SML_POS_W-1:0] i_measured_position,
  input wire logic i_motor_stopped,
  input wire servo_motion_limiter_pkg::profile_type i_profile_request,
  // end switch pins
  input wire logic i_pos_end_switch,
  input wire logic i_neg_end_switch,
  // limited demands
  output logic signed [`SML_SPD_W-1:0] o_speed_limited,
  output logic signed [`SML_TQ_W-1:0] o_torque_limited,
  output servo_motion_limiter_pkg::profile_type o_profile_limited,
  output logic [`SML_TQ_W-1:0] o_applied_torque_limit_pos,
  output logic [`SML_TQ_W-1:0] o_applied_torque_limit_neg,
  // stop control and drive state
  output logic o_quick_stop,
  output logic [`SML_ACC_W-1:0] o_decel_rate,
  output servo_motion_limiter_pkg::drive_state_type o_drive_state,
  // warnings
  output logic o_limit_reached,
  output logic [5:0] o_limit_detail,
  output logic o_param_limited,
  output logic [2:0] o_param_detail,
  output logic o_param_soft_error,
  output logic [0:0] o_param_soft_detail
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [`SML_SPD_W-1:0] umin32(input logic [`SML_SPD_W-1:0] a,
                                                   input logic [`SML_SPD_W-1:0] b);
    umin32 = (a < b) ? a : b;
  endfunction

  // quick stop ramps at the profile decel ceiling; no rate port of its own
  // so lowering that ceiling also softens the quick stop
  logic [`SML_ACC_W-1:0] emergency_decel_rate;
  assign emergency_decel_rate = i_motion_cfg.profile_decel_ceiling;

  //////////////////////////////////////////////////////////////////////////////
  // end switch synchronisers

  // a switch held through reset still needs two edges
  logic [1:0] pos_sw_sync_r;
  logic [1:0] neg_sw_sync_r;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pos_sw_sync_r <= 2'h0;
      neg_sw_sync_r <= 2'h0;
    end else begin
      pos_sw_sync_r <= {pos_sw_sync_r[0], i_pos_end_switch};
      neg_sw_sync_r <= {neg_sw_sync_r[0], i_neg_end_switch};
    end
  end

  logic end_pos;
  logic end_neg;

  // switches in the far half only; the first stage feeds nothing else
  assign end_pos = i_polarity_reverse ? neg_sw_sync_r[1] : pos_sw_sync_r[1];
  assign end_neg = i_polarity_reverse ? pos_sw_sync_r[1] : neg_sw_sync_r[1];

  //////////////////////////////////////////////////////////////////////////////
  // torque limit

  logic tq_clamping;

  // limits arrive already scaled to tenths of a percent of stall current
  torque_limit_select u_torque_limit_select (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_cfg(i_torque_cfg),
    .i_torque_demand(i_torque_request),
    .o_limit_pos(o_applied_torque_limit_pos),
    .o_limit_neg(o_applied_torque_limit_neg),
    .o_torque_out(o_torque_limited),
    .o_clamping(tq_clamping)
  );

  //////////////////////////////////////////////////////////////////////////////
  // request sign and limit detection

  logic torque_mode;
  logic speed_mode;
  logic req_pos;
  logic req_neg;

  // torque modes take direction from the torque demand
  assign torque_mode = (i_op_mode == `SML_MODE_TORQUE);
  assign speed_mode = (i_op_mode == `SML_MODE_SPEED) || (i_op_mode == `SML_MODE_POSITION);
  assign req_pos = torque_mode ? (i_torque_request > 0) : (i_speed_request > 0);
  assign req_neg = torque_mode ? (i_torque_request < 0) : (i_speed_request < 0);

  logic hw_pos_hit;
  logic hw_neg_hit;
  logic sw_pos_hit;
  logic sw_neg_hit;

  // a switch on the far side of the request is ignored
  assign hw_pos_hit = i_op_enabled && req_pos && end_pos;
  assign hw_neg_hit = i_op_enabled && req_neg && end_neg;

  assign sw_pos_hit = i_op_enabled && i_travel_cfg.soft_travel_limit_on && req_pos &&
                      (i_measured_position > $signed(i_travel_cfg.soft_travel_max));
  assign sw_neg_hit = i_op_enabled && i_travel_cfg.soft_travel_limit_on && req_neg &&
                      (i_measured_position < $signed(i_travel_cfg.soft_travel_min));

  // one hit is enough to start the ramp
  logic any_hit;
  assign any_hit = hw_pos_hit || hw_neg_hit || sw_pos_hit || sw_neg_hit;

  //////////////////////////////////////////////////////////////////////////////
  // drive state: quick stop active while decelerating on a limit

  // the ramp itself runs in the speed loop
  servo_motion_limiter_pkg::drive_state_type state_r;
  servo_motion_limiter_pkg::drive_state_type state_nxt;

  always_comb begin
    case (state_r)
      servo_motion_limiter_pkg::DRV_OP_ENABLED: begin
        state_nxt = any_hit ? servo_motion_limiter_pkg::DRV_QUICK_STOP : state_r;
      end
      servo_motion_limiter_pkg::DRV_QUICK_STOP: begin
        // leave only once stationary, so a bounced switch cannot restart the ramp
        state_nxt = i_motor_stopped ? servo_motion_limiter_pkg::DRV_OP_ENABLED : state_r;
      end
      default: begin
        state_nxt = servo_motion_limiter_pkg::DRV_OP_ENABLED;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= servo_motion_limiter_pkg::DRV_OP_ENABLED;
      o_drive_state <= servo_motion_limiter_pkg::DRV_OP_ENABLED;
      o_quick_stop <= 1'b0;
    end else begin
      state_r <= state_nxt;
      o_drive_state <= state_nxt;
      o_quick_stop <= (state_nxt == servo_motion_limiter_pkg::DRV_QUICK_STOP);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_decel_rate <= '0;
    end else begin
      o_decel_rate <= emergency_decel_rate;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // speed clamp

  logic signed [`SML_SPD_W:0] spd_ext;
  logic signed [`SML_SPD_W:0] cap_pos;
  logic signed [`SML_SPD_W:0] cap_neg;
  logic spd_clamp_hi;
  logic spd_clamp_lo;

  // spare bit so the negated ceiling cannot wrap
  assign spd_ext = {i_speed_request[`SML_SPD_W-1], i_speed_request};
  assign cap_pos = {1'b0, i_motion_cfg.speed_ceiling};
  assign cap_neg = -cap_pos;
  assign spd_clamp_hi = speed_mode && (spd_ext > cap_pos);
  assign spd_clamp_lo = speed_mode && (spd_ext < cap_neg);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_speed_limited <= '0;
    end else if (spd_clamp_hi) begin
      o_speed_limited <= cap_pos[`SML_SPD_W-1:0];
    end else if (spd_clamp_lo) begin
      o_speed_limited <= cap_neg[`SML_SPD_W-1:0];
    end else begin
      o_speed_limited <= i_speed_request;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // limit-reached warning, refreshed every cycle

  logic [5:0] detail_nxt;

  always_comb begin
    detail_nxt = `SML_RST_DETAIL;
    detail_nxt[`SML_LIM_TORQUE] = tq_clamping;
    detail_nxt[`SML_LIM_SPEED] = spd_clamp_hi || spd_clamp_lo;
    detail_nxt[`SML_LIM_HW_POS] = hw_pos_hit;
    detail_nxt[`SML_LIM_HW_NEG] = hw_neg_hit;
    detail_nxt[`SML_LIM_SW_POS] = sw_pos_hit;
    detail_nxt[`SML_LIM_SW_NEG] = sw_neg_hit;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_limit_detail <= `SML_RST_DETAIL;
      o_limit_reached <= 1'b0;
    end else begin
      o_limit_detail <= detail_nxt;
      o_limit_reached <= |detail_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // soft limit consistency

  logic soft_crossed;

  assign soft_crossed = $signed(i_travel_cfg.soft_travel_max) <
                        $signed(i_travel_cfg.soft_travel_min);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_param_soft_error <= 1'b0;
      o_param_soft_detail <= 1'h0;
    end else begin
      // checked regardless of enable, the master programs both before enabling
      o_param_soft_error <= soft_crossed;
      o_param_soft_detail[`SML_ERR_SOFT_LIMITS] <= soft_crossed;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // profile parameter clamp

  logic [`SML_SPD_W-1:0] prof_spd_cap;
  logic [2:0] prm_nxt;

  assign prof_spd_cap = umin32(i_motion_cfg.profile_speed_ceiling,
                               i_motion_cfg.speed_ceiling);

  // flags use the raw request, not the clamped one
  always_comb begin
    prm_nxt = `SML_RST_PRM;
    prm_nxt[`SML_PRM_SPEED] = i_profile_request.speed > prof_spd_cap;
    prm_nxt[`SML_PRM_ACCEL] = i_profile_request.accel > i_motion_cfg.profile_accel_ceiling;
    prm_nxt[`SML_PRM_DECEL] = i_profile_request.decel > i_motion_cfg.profile_decel_ceiling;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_profile_limited <= '0;
      o_param_detail <= `SML_RST_PRM;
      o_param_limited <= 1'b0;
    end else begin
      o_profile_limited.speed <= umin32(i_profile_request.speed, prof_spd_cap);
      o_profile_limited.accel <= umin32(i_profile_request.accel,
                                        i_motion_cfg.profile_accel_ceiling);
      o_profile_limited.decel <= umin32(i_profile_request.decel,
                                        i_motion_cfg.profile_decel_ceiling);
      o_param_detail <= prm_nxt;
      o_param_limited <= |prm_nxt;
    end
  end

endmodule // servo_motion_limiter

// *** testbench/servo_motion_limiter_properties.sv ***
// servo_motion_limiter_properties: port-level checks of the motion limiter
// assumes it is bound into servo_motion_limiter and sees only its ports
`timescale 1ns/1ps
module servo_motion_limiter_properties (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // watched inputs
  input wire servo_motion_limiter_pkg::torque_cfg_type i_torque_cfg,
  input wire servo_motion_limiter_pkg::motion_cfg_type i_motion_cfg,
  input wire servo_motion_limiter_pkg::travel_cfg_type i_travel_cfg,
  input wire logic [1:0] i_op_mode,
  input wire logic signed [31:0] i_speed_request,
  input wire logic i_motor_stopped,
  input wire servo_motion_limiter_pkg::profile_type i_profile_request,
  // watched outputs
  input wire logic signed [31:0] o_speed_limited,
  input wire servo_motion_limiter_pkg::profile_type o_profile_limited,
  input wire logic [15:0] o_applied_torque_limit_pos,
  input wire logic [15:0] o_applied_torque_limit_neg,
  input wire logic o_quick_stop,
  input wire logic [31:0] o_decel_rate,
  input wire servo_motion_limiter_pkg::drive_state_type o_drive_state,
  input wire logic o_limit_reached,
  input wire logic [5:0] o_limit_detail,
  input wire logic o_param_limited,
  input wire logic [2:0] o_param_detail,
  input wire logic o_param_soft_error
);
  logic [1:0] sel;
  logic [15:0] cap;
  logic [31:0] acc;
  logic spd_mode;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  assign sel = i_torque_cfg.torque_limit_source_sel;
  assign cap = i_torque_cfg.user_current_ceiling < i_torque_cfg.rated_current_ceiling ?
    i_torque_cfg.user_current_ceiling : i_torque_cfg.rated_current_ceiling;
  assign acc = i_profile_request.accel < i_motion_cfg.profile_accel_ceiling ?
    i_profile_request.accel : i_motion_cfg.profile_accel_ceiling;
  assign spd_mode = i_op_mode == 2'h1 || i_op_mode == 2'h2;
  ////////////////////////////////////////
  a_peak_cap_pos: assert property (
    sel == 2'h0 |=> o_applied_torque_limit_pos == $past(cap)) else $error("peak limit wrong");
  a_peak_symmetric: assert property (
    sel == 2'h0 |=> o_applied_torque_limit_neg == o_applied_torque_limit_pos)
    else $error("peak limits differ");
  a_speed_ceiling: assert property (
    spd_mode && i_speed_request > $signed(i_motion_cfg.speed_ceiling)
    |=> o_speed_limited == $past(i_motion_cfg.speed_ceiling)) else $error("speed not clamped");
  a_torque_mode_pass: assert property (
    i_op_mode == 2'h0 |=> o_speed_limited == $past(i_speed_request) && !o_limit_detail[1])
    else $error("speed clamped in torque mode");
  a_accel_clamp: assert property (
    1'b1 |=> o_profile_limited.accel == $past(acc)) else $error("accel clamp wrong");
  a_param_summary: assert property (
    o_param_limited == |o_param_detail) else $error("param warning mismatch");
  a_soft_incompat: assert property (
    $signed(i_travel_cfg.soft_travel_max) < $signed(i_travel_cfg.soft_travel_min)
    |=> o_param_soft_error) else $error("soft error missing");
  a_qs_release: assert property (
    o_quick_stop && i_motor_stopped |=> !o_quick_stop) else $error("quick stop not left");
  a_qs_hold: assert property (
    o_quick_stop && !i_motor_stopped |=> o_quick_stop) else $error("quick stop dropped");
  a_state_mirror: assert property (
    o_quick_stop == (o_drive_state == servo_motion_limiter_pkg::DRV_QUICK_STOP))
    else $error("drive state mismatch");
  a_decel_rate: assert property (
    1'b1 |=> o_decel_rate == $past(i_motion_cfg.profile_decel_ceiling))
    else $error("decel rate wrong");
  a_warn_summary: assert property (
    o_limit_reached == |o_limit_detail) else $error("limit warning mismatch");
endmodule // servo_motion_limiter_properties

bind servo_motion_limiter servo_motion_limiter_properties u_servo_motion_limiter_properties (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_torque_cfg(i_torque_cfg),
  .i_motion_cfg(i_motion_cfg), .i_travel_cfg(i_travel_cfg), .i_op_mode(i_op_mode),
  .i_speed_request(i_speed_request), .i_motor_stopped(i_motor_stopped),
  .i_profile_request(i_profile_request), .o_speed_limited(o_speed_limited),
  .o_profile_limited(o_profile_limited), .o_applied_torque_limit_pos(o_applied_torque_limit_pos),
  .o_applied_torque_limit_neg(o_applied_torque_limit_neg), .o_quick_stop(o_quick_stop),
  .o_decel_rate(o_decel_rate), .o_drive_state(o_drive_state), .o_limit_reached(o_limit_reached),
  .o_limit_detail(o_limit_detail), .o_param_limited(o_param_limited),
  .o_param_detail(o_param_detail), .o_param_soft_error(o_param_soft_error));

// *** testbench/end_switch_partner.sv ***
// end_switch_partner: end-of-travel switches of the axis, active high pins
// assumes the position changes shortly after the clock edge
`timescale 1ns/1ps
module end_switch_partner #(
  parameter int HI_END = 262144,
  parameter int LO_END = -262144
) (
  // axis position
  input wire logic signed [31:0] i_position,
  // switch pins
  output logic o_pos_pin,
  output logic o_neg_pin
);
  // no debounce here: the drive synchronises the pins itself
  assign o_pos_pin = i_position >= HI_END;
  assign o_neg_pin = i_position <= LO_END;
endmodule // end_switch_partner

// *** testbench/servo_motion_limiter_tb_top.sv ***
// servo_motion_limiter_tb_top: random stimulus against a reference model
// assumes the design files and end_switch_partner are compiled first
`timescale 1ns/1ps
module servo_motion_limiter_tb_top;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  servo_motion_limiter_pkg::torque_cfg_type tq = '0;
  servo_motion_limiter_pkg::motion_cfg_type mc = '0;
  servo_motion_limiter_pkg::travel_cfg_type tc = '0;
  servo_motion_limiter_pkg::profile_type pr = '0, po, e_po;
  servo_motion_limiter_pkg::drive_state_type ds;
  logic rev = 1'b0, oen = 1'b0, stp = 1'b0, psw, nsw, qs, lr, pl, se, pe, ne;
  logic s1p, s2p, s1n, s2n, e_qs, e_se;
  logic [1:0] mode = 2'h0;
  logic signed [31:0] spd = '0, pos = '0, so, e_so;
  logic signed [15:0] trq = '0, to, e_to;
  logic [15:0] ap, an, e_ap, e_an;
  logic [31:0] dr, e_dr, rs = 32'h0000D24D, r;
  logic [127:0] w;
  logic [5:0] ld, e_ld;
  logic [2:0] pd, e_pd;
  logic [0:0] sd;
  int miscompares = 0, samples_checked = 0, cap, lp, ln, t, s, sc, ps, q;

  always #2.5 i_clk_sys = ~i_clk_sys;

  servo_motion_limiter u_servo_motion_limiter (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_torque_cfg(tq), .i_motion_cfg(mc), .i_travel_cfg(tc), .i_polarity_reverse(rev),
    .i_op_mode(mode), .i_op_enabled(oen), .i_speed_request(spd), .i_torque_request(trq),
    .i_measured_position(pos), .i_motor_stopped(stp), .i_profile_request(pr),
    .i_pos_end_switch(psw), .i_neg_end_switch(nsw), .o_speed_limited(so),
    .o_torque_limited(to), .o_profile_limited(po), .o_applied_torque_limit_pos(ap),
    .o_applied_torque_limit_neg(an), .o_quick_stop(qs), .o_decel_rate(dr), .o_drive_state(ds),
    .o_limit_reached(lr), .o_limit_detail(ld), .o_param_limited(pl), .o_param_detail(pd),
    .o_param_soft_error(se), .o_param_soft_detail(sd));

  end_switch_partner u_end_switch_partner (.i_position(pos), .o_pos_pin(psw), .o_neg_pin(nsw));

  ////////////////////////////////////////
  function automatic int mn(int a, int b);
    return a < b ? a : b;
  endfunction

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(logic [127:0] v, logic [127:0] e);
    samples_checked++;
    if (v !== e) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, v, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // reference model, one result per control cycle
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      {s1p, s2p, s1n, s2n, e_qs, e_se, e_ld, e_pd} = '0;
      {e_so, e_to, e_ap, e_an, e_po, e_dr} = '0;
    end else begin
      cap = mn(tq.user_current_ceiling, tq.rated_current_ceiling);
      lp = cap;
      ln = cap;
      if (tq.torque_limit_source_sel == servo_motion_limiter_pkg::SEL_TORQUE) begin
        lp = mn(cap, mn(tq.torque_ceiling, tq.torque_limit_pos_value));
        ln = mn(cap, mn(tq.torque_ceiling, tq.torque_limit_neg_value));
      end
      if (tq.torque_limit_source_sel == servo_motion_limiter_pkg::SEL_ANALOG) begin
        lp = mn(cap, tq.analog_torque_limit);
        ln = lp;
      end
      e_ap = 16'(lp);
      e_an = 16'(ln);
      t = trq;
      e_ld[0] = t > lp || t < -ln;
      e_to = 16'(t > lp ? lp : (t < -ln ? -ln : t));
      s = spd;
      sc = mc.speed_ceiling;
      e_ld[1] = (mode == 2'h1 || mode == 2'h2) && (s > sc || s < -sc);
      e_so = e_ld[1] ? (s > 0 ? sc : -sc) : s;
      q = mode == 2'h0 ? t : s;
      pe = rev ? s2n : s2p;
      ne = rev ? s2p : s2n;
      e_ld[2] = oen && q > 0 && pe;
      e_ld[3] = oen && q < 0 && ne;
      e_ld[4] = oen && tc.soft_travel_limit_on && q > 0 && pos > $signed(tc.soft_travel_max);
      e_ld[5] = oen && tc.soft_travel_limit_on && q < 0 && pos < $signed(tc.soft_travel_min);
      e_qs = e_qs ? !stp : |e_ld[5:2];
      e_se = $signed(tc.soft_travel_max) < $signed(tc.soft_travel_min);
      ps = mn(mc.profile_speed_ceiling, mc.speed_ceiling);
      e_pd = {pr.decel > mc.profile_decel_ceiling, pr.accel > mc.profile_accel_ceiling,
        pr.speed > ps};
      e_po.speed = mn(pr.speed, ps);
      e_po.accel = mn(pr.accel, mc.profile_accel_ceiling);
      e_po.decel = mn(pr.decel, mc.profile_decel_ceiling);
      e_dr = mc.profile_decel_ceiling;
      s2p = s1p;
      s1p = psw;
      s2n = s1n;
      s1n = nsw;
    end
  end

  always @(negedge i_clk_sys) begin
    chk(so, e_so);
    chk(to, e_to);
    chk(ap, e_ap);
    chk(an, e_an);
    chk(po, e_po);
    chk(qs, e_qs);
    chk(ds, e_qs);
    chk(dr, e_dr);
    chk(ld, e_ld);
    chk(lr, |e_ld);
    chk(pd, e_pd);
    chk(pl, |e_pd);
    chk({se, sd}, {2{e_se}});
  end

  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clk_sys);
    #1 i_resetn = 1'b1;
    for (int b = 0; b < 8; b++) begin
      for (int k = 0; k < 300; k++) begin
        @(posedge i_clk_sys);
        #1;
        // park clear of the switches before flipping polarity, so no synced edge is swapped
        if (k < 4) begin
          pos = '0;
          rev = (k == 3) ? b[0] : rev;
        end else begin
          w = {rnd(), rnd(), rnd(), rnd()};
          tq = w[97:0] & {{6{16'h07FF}}, 2'h3};
          mc = {rnd(), rnd(), rnd(), rnd()} & {4{32'h0001FFFF}};
          w = {rnd(), rnd(), rnd(), rnd()};
          pr = w[95:0] & {3{32'h0001FFFF}};
          tc.soft_travel_max = (rnd() & 32'h001FFFFF) - 32'h00100000;
          tc.soft_travel_min = (rnd() & 32'h001FFFFF) - 32'h00100000;
          pos = (rnd() & 32'h001FFFFF) - 32'h00100000;
          r = (rnd() & 32'h001FFFFF) - 32'h00100000;
          spd = $signed(r) >>> 3;
          trq = {{4{r[19]}}, r[19:8]};
          r = rnd();
          tc.soft_travel_limit_on = r[7];
          oen = r[0] | r[1];
          stp = r[4:2] == 3'h0;
          mode = (r[6:5] == 2'h3) ? 2'h1 : r[6:5];
        end
      end
      if (b == 4) begin
        i_resetn = 1'b0;
        @(posedge i_clk_sys);
        #1 i_resetn = 1'b1;
      end
    end
    tally_and_finish();
  end

  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
endmodule // servo_motion_limiter_tb_top
